// ---- asp_top.sv ----
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module asp_top (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic SERIAL_TRANSMIT_PIN,
  input wire logic SERIAL_RECEIVE_PIN,
  input wire logic EXT_OSC_CLK_IN,
  input wire logic BAUD_TIMER_EXTERNAL_INPUT,
  output logic IRQ
);
  import asp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic rst_meta_q, rst_n_q;
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  logic os_s1_q, os_s2_q, os_s3_q;
  logic ex_s1_q, ex_s2_q, ex_s3_q;

  // Reset released through two flops
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Two flops per pin, third flop for edge detection
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      {rx_s1_q, rx_s2_q, rx_s3_q} <= 3'h7;
      {os_s1_q, os_s2_q, os_s3_q} <= 3'h0;
      {ex_s1_q, ex_s2_q, ex_s3_q} <= 3'h0;
    end else begin
      {rx_s1_q, rx_s2_q, rx_s3_q} <= {SERIAL_RECEIVE_PIN, rx_s1_q, rx_s2_q};
      {os_s1_q, os_s2_q, os_s3_q} <= {EXT_OSC_CLK_IN, os_s1_q, os_s2_q};
      {ex_s1_q, ex_s2_q, ex_s3_q} <= {BAUD_TIMER_EXTERNAL_INPUT, ex_s1_q,
                                      ex_s2_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic ack_q, ack_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [7:0] reload_q, reload_d;
  logic [2:0] src_q, src_d;
  logic run_q, run_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] rx_buf_q, rx_buf_d;
  logic [7:0] tmr_q;
  logic wr_acc, rd_acc, data_wr, tx_done_ev, rx_load_ev, rx_b9;
  logic [7:0] rx_byte_q;

  assign wr_acc = AVS_WRITE && ack_q;
  assign rd_acc = AVS_READ && ack_q;
  assign data_wr = wr_acc && AVS_ADDRESS == ASP_OFF_DATA && AVS_BYTEENABLE[0];
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
  assign AVS_READDATA = rdata_q;
  assign IRQ = |(stat_q & mask_q);

  // Register writes, read mux and flag updates
  always_comb begin
    ack_d = (AVS_READ || AVS_WRITE) && !ack_q;
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    mask_d = mask_q;
    reload_d = reload_q;
    src_d = src_q;
    run_d = run_q;
    rdata_d = rdata_q;
    rx_buf_d = rx_buf_q;
    if (wr_acc && AVS_BYTEENABLE[0]) begin
      case (AVS_ADDRESS)
        ASP_OFF_CTRL: ctrl_d = AVS_WRITEDATA[7:0];
        ASP_OFF_STAT: stat_d = stat_q & ~AVS_WRITEDATA[1:0];
        ASP_OFF_MASK: mask_d = AVS_WRITEDATA[1:0];
        ASP_OFF_TMR: reload_d = AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
    if (wr_acc && AVS_BYTEENABLE[1] && AVS_ADDRESS == ASP_OFF_TMR) begin
      src_d = AVS_WRITEDATA[ASP_TM_SEL_LSB +: 3];
      run_d = AVS_WRITEDATA[ASP_TM_RUN];
    end
    ctrl_d[ASP_CTL_ONE] = 1'b0;
    // Hardware set wins over a same-cycle software clear
    if (tx_done_ev) stat_d[ASP_ST_TX] = 1'b1;
    if (rx_load_ev) begin
      stat_d[ASP_ST_RX] = 1'b1;
      rx_buf_d = rx_byte_q;
      ctrl_d[ASP_CTL_RB8] = rx_b9;
    end
    // Read data latched in the wait cycle so it stands at the taking edge
    if (AVS_READ && !ack_q) begin
      case (AVS_ADDRESS)
        ASP_OFF_CTRL: rdata_d = {24'h0, ctrl_q | 8'h40};
        ASP_OFF_DATA: rdata_d = {24'h0, rx_buf_q};
        ASP_OFF_STAT: rdata_d = {30'h0, stat_q};
        ASP_OFF_MASK: rdata_d = {30'h0, mask_q};
        ASP_OFF_TMR: rdata_d = {8'h0, tmr_q, 4'h0, run_q, src_q, reload_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Register bank
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      ctrl_q <= ASP_CTRL_RST;
      stat_q <= 2'h0;
      mask_q <= ASP_MASK_RST;
      reload_q <= ASP_RELOAD_RST;
      src_q <= ASP_SRC_SYS;
      run_q <= 1'b0;
      rdata_q <= 32'h0;
      rx_buf_q <= 8'h00;
    end else begin
      ack_q <= ack_d;
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      reload_q <= reload_d;
      src_q <= src_d;
      run_q <= run_d;
      rdata_q <= rdata_d;
      rx_buf_q <= rx_buf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer clock selection, counters and divide-by-two
  logic [5:0] pre_q, pre_d;
  logic [2:0] osc_q, osc_d;
  logic [7:0] tmr_d, rxt_q, rxt_d;
  logic tx_div_q, tx_div_d, rx_ph_q, rx_ph_d;
  logic tick, tx_ovf, rx_ovf, tx_baud, rx_samp, start_det;

  // Next count with auto-reload on overflow
  function automatic logic [7:0] asp_next(input logic [7:0] c,
                                          input logic [7:0] r);
    asp_next = (c == 8'hFF) ? r : c + 8'h01;
  endfunction

  // Clock source mux
  always_comb begin
    case (src_q)
      ASP_SRC_SYS: tick = 1'b1;
      ASP_SRC_DIV4: tick = pre_q[1:0] == 2'h3;
      ASP_SRC_DIV12: tick = pre_q == 6'h0B || pre_q == 6'h17 ||
                            pre_q == 6'h23 || pre_q == 6'h2F;
      ASP_SRC_DIV48: tick = pre_q == ASP_PRE_LAST;
      ASP_SRC_OSC8: tick = os_s2_q && !os_s3_q && osc_q == 3'h7;
      ASP_SRC_EXT: tick = !ex_s2_q && ex_s3_q;
      default: tick = 1'b0;
    endcase
  end

  assign tx_ovf = run_q && tick && tmr_q == 8'hFF;
  assign rx_ovf = run_q && tick && rxt_q == 8'hFF;
  assign tx_baud = tx_ovf && tx_div_q;
  assign rx_samp = rx_ovf && !rx_ph_q;

  // Counter next values
  always_comb begin
    pre_d = (pre_q == ASP_PRE_LAST) ? 6'h00 : pre_q + 6'h01;
    osc_d = (os_s2_q && !os_s3_q) ? osc_q + 3'h1 : osc_q;
    tmr_d = tmr_q;
    rxt_d = rxt_q;
    tx_div_d = tx_ovf ? !tx_div_q : tx_div_q;
    rx_ph_d = rx_ovf ? !rx_ph_q : rx_ph_q;
    if (run_q && tick) begin
      tmr_d = asp_next(tmr_q, reload_q);
      rxt_d = asp_next(rxt_q, reload_q);
    end
    if (start_det) begin
      rxt_d = reload_q;
      rx_ph_d = 1'b0;
    end
  end

  // Counter registers; receive copy is never readable
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_q <= 6'h00;
      osc_q <= 3'h0;
      tmr_q <= 8'h00;
      rxt_q <= 8'h00;
      tx_div_q <= 1'b0;
      rx_ph_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      osc_q <= osc_d;
      tmr_q <= tmr_d;
      rxt_q <= rxt_d;
      tx_div_q <= tx_div_d;
      rx_ph_q <= rx_ph_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  asp_tx_t tx_st_q, tx_st_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_cnt_q, tx_cnt_d;
  logic tx_pin_q, tx_pin_d;
  logic nine;

  assign nine = ctrl_q[ASP_CTL_WIDTH];
  assign SERIAL_TRANSMIT_PIN = tx_pin_q;

  // Frame loading and bit shifting
  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    tx_pin_d = tx_pin_q;
    tx_done_ev = 1'b0;
    case (tx_st_q)
      ASP_TX_SHIFT: begin
        if (tx_baud) begin
          if (tx_cnt_q == 4'h0) begin
            tx_st_d = ASP_TX_IDLE;
          end else begin
            tx_pin_d = tx_sh_q[0];
            tx_sh_d = {1'b1, tx_sh_q[10:1]};
            tx_cnt_d = tx_cnt_q - 4'h1;
            tx_done_ev = tx_cnt_q == 4'h1;
          end
        end
      end
      default: tx_pin_d = 1'b1;
    endcase
    if (data_wr) begin
      tx_st_d = ASP_TX_SHIFT;
      tx_cnt_d = nine ? ASP_LEN9 : ASP_LEN8;
      tx_sh_d = {1'b1, nine ? ctrl_q[ASP_CTL_TB8] : 1'b1,
                 AVS_WRITEDATA[7:0], 1'b0};
    end
  end

  // Transmit registers
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_st_q <= ASP_TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_pin_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      tx_pin_q <= tx_pin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  asp_rx_t rx_st_q, rx_st_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] rx_byte_d;
  logic rx_b9_q, rx_b9_d, last;

  assign start_det = rx_st_q == ASP_RX_IDLE && ctrl_q[ASP_CTL_REN] &&
                     !rx_s2_q && rx_s3_q;
  assign last = rx_cnt_q == (nine ? ASP_LEN9 : ASP_LEN8) - 4'h1;
  assign rx_b9 = nine ? rx_b9_q : rx_s2_q;

  // Bit sampling at mid-bit and end-of-frame load
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_byte_d = rx_byte_q;
    rx_b9_d = rx_b9_q;
    rx_load_ev = 1'b0;
    case (rx_st_q)
      ASP_RX_BITS: begin
        if (rx_samp) begin
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == 4'h0 && rx_s2_q) begin
            rx_st_d = ASP_RX_IDLE;
          end else if (last) begin
            rx_st_d = ASP_RX_IDLE;
            rx_load_ev = !stat_q[ASP_ST_RX] &&
                         (!ctrl_q[ASP_CTL_MCE] || rx_b9);
          end else if (rx_cnt_q == 4'h9) begin
            rx_b9_d = rx_s2_q;
          end else if (rx_cnt_q != 4'h0) begin
            rx_byte_d = {rx_s2_q, rx_byte_q[7:1]};
          end
        end
      end
      default: begin
        if (start_det) begin
          rx_st_d = ASP_RX_BITS;
          rx_cnt_d = 4'h0;
        end
      end
    endcase
  end

  // Receive registers
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_st_q <= ASP_RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_byte_q <= 8'h00;
      rx_b9_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_byte_q <= rx_byte_d;
      rx_b9_q <= rx_b9_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  tx_idle_high_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (tx_st_q == ASP_TX_IDLE && !$past(tx_baud)) |-> tx_pin_q)
    else $error("line not high while idle");
  tx_start_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    data_wr |=> tx_st_q == ASP_TX_SHIFT && tx_sh_q[0] == 1'b0)
    else $error("data write did not start frame");
  data_read_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (rd_acc && AVS_ADDRESS == ASP_OFF_DATA) |->
    AVS_READDATA == {24'h0, $past(rx_buf_q)})
    else $error("data read not from receive buffer");
  tx_done_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    tx_done_ev |=> stat_q[ASP_ST_TX] && tx_pin_q)
    else $error("done flag not set at stop bit");
  irq_level_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    IRQ == ((stat_q[0] && mask_q[0]) || (stat_q[1] && mask_q[1])))
    else $error("interrupt level wrong");
  flag_hold_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    (stat_q[ASP_ST_RX] && !(wr_acc && AVS_ADDRESS == ASP_OFF_STAT))
    |=> stat_q[ASP_ST_RX])
    else $error("receive flag cleared by hardware");
  rx_reload_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    start_det |=> rxt_q == $past(reload_q) && rx_st_q == ASP_RX_BITS)
    else $error("start did not reload receive timer");
  rx_guard_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    $changed(rx_buf_q) |-> !$past(stat_q[ASP_ST_RX]))
    else $error("buffer overwritten while flag set");
  baud_half_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_q)
    tx_baud |=> !tx_div_q)
    else $error("transmit divider not toggling");
endmodule

// ---- asp_pkg.sv ----
package asp_pkg;
  // Register byte offsets
  localparam logic [4:0] ASP_OFF_CTRL = 5'h00;
  localparam logic [4:0] ASP_OFF_DATA = 5'h04;
  localparam logic [4:0] ASP_OFF_STAT = 5'h08;
  localparam logic [4:0] ASP_OFF_MASK = 5'h0C;
  localparam logic [4:0] ASP_OFF_TMR = 5'h10;
  // Control register fields
  localparam int ASP_CTL_WIDTH = 7;
  localparam int ASP_CTL_ONE = 6;
  localparam int ASP_CTL_MCE = 5;
  localparam int ASP_CTL_REN = 4;
  localparam int ASP_CTL_TB8 = 3;
  localparam int ASP_CTL_RB8 = 2;
  // Status and mask fields
  localparam int ASP_ST_RX = 0;
  localparam int ASP_ST_TX = 1;
  // Timer register fields
  localparam int ASP_TM_SEL_LSB = 8;
  localparam int ASP_TM_RUN = 11;
  localparam int ASP_TM_CNT_LSB = 16;
  // Reset values
  localparam logic [7:0] ASP_CTRL_RST = 8'h00;
  localparam logic [1:0] ASP_MASK_RST = 2'h0;
  localparam logic [7:0] ASP_RELOAD_RST = 8'h00;
  // Timer clock sources
  localparam logic [2:0] ASP_SRC_SYS = 3'h0;
  localparam logic [2:0] ASP_SRC_DIV4 = 3'h1;
  localparam logic [2:0] ASP_SRC_DIV12 = 3'h2;
  localparam logic [2:0] ASP_SRC_DIV48 = 3'h3;
  localparam logic [2:0] ASP_SRC_OSC8 = 3'h4;
  localparam logic [2:0] ASP_SRC_EXT = 3'h5;
  // Prescaler and frame figures
  localparam logic [5:0] ASP_PRE_LAST = 6'h2F;
  localparam logic [3:0] ASP_LEN8 = 4'hA;
  localparam logic [3:0] ASP_LEN9 = 4'hB;
  // Serial state machines
  typedef enum logic [1:0] {ASP_TX_IDLE = 2'b00, ASP_TX_SHIFT = 2'b01} asp_tx_t;
  typedef enum logic [1:0] {ASP_RX_IDLE = 2'b00, ASP_RX_BITS = 2'b01} asp_rx_t;
endpackage

// ---- asp_remote.sv ----
`timescale 1ns/1ps
// Far-side station: sends frames on demand and captures frames
module asp_remote (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_cyc = 16;
  int nbits = 8;
  logic [10:0] got_q[$];

  // Line idles high between frames
  initial line_out = 1'b1;

  // Start bit, data LSB first, ninth if any, then stop
  task automatic send(input logic [8:0] d, input logic stp);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= d[i];
      repeat (bit_cyc) @(posedge clk);
    end
    line_out <= stp;
    repeat (bit_cyc) @(posedge clk);
    line_out <= 1'b1;
  endtask

  // Capture from the falling edge, each bit sampled mid-way
  always begin : capture
    logic [10:0] f;
    @(negedge line_in);
    f = '0;
    repeat (bit_cyc / 2) @(posedge clk);
    f[0] = line_in;
    for (int i = 1; i <= nbits + 1; i++) begin
      repeat (bit_cyc) @(posedge clk);
      f[i] = line_in;
    end
    got_q.push_back(f);
  end
endmodule

// ---- asp_top_tb.sv ----
`timescale 1ns/1ps
module asp_top_tb;
  import asp_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic EXT_OSC_CLK_IN = 1'b0;
  logic BAUD_TIMER_EXTERNAL_INPUT = 1'b0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic SERIAL_TRANSMIT_PIN;
  logic SERIAL_RECEIVE_PIN;
  logic IRQ;
  int num_errors = 0;
  int checked = 0;

  asp_top i_dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .SERIAL_TRANSMIT_PIN(SERIAL_TRANSMIT_PIN),
    .SERIAL_RECEIVE_PIN(SERIAL_RECEIVE_PIN),
    .EXT_OSC_CLK_IN(EXT_OSC_CLK_IN),
    .BAUD_TIMER_EXTERNAL_INPUT(BAUD_TIMER_EXTERNAL_INPUT), .IRQ(IRQ));
  asp_remote i_remote (.clk(SYS_CLK), .line_in(SERIAL_TRANSMIT_PIN),
    .line_out(SERIAL_RECEIVE_PIN));

  ////////////////////////////////////////////////////////////////////
  // System clock plus the two slow timer sources
  always #50 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    EXT_OSC_CLK_IN <= ~EXT_OSC_CLK_IN;
    BAUD_TIMER_EXTERNAL_INPUT <= ~BAUD_TIMER_EXTERNAL_INPUT;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    // Sample waitrequest at each rising edge; data taken at the same edge
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (AVS_WAITREQUEST !== 1'b0) chk(32'(AVS_WAITREQUEST), 32'h0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    // Let one edge pass so the next request never reuses this time step
    @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Poll status until bit b is set, bounded
  task automatic wait_st(input int b);
    logic [31:0] q;
    q = 32'h0;
    repeat (60) if (q[b] !== 1'b1) bus(1'b0, ASP_OFF_STAT, 32'h0, q);
    chk(32'(q[b]), 32'h1);
  endtask

  task automatic frame(input logic [10:0] e);
    repeat (3000) if (i_remote.got_q.size() == 0) @(posedge SYS_CLK);
    if (i_remote.got_q.size() > 0) chk(32'(i_remote.got_q.pop_front()), 32'(e));
    else chk(32'hDEAD, 32'(e));
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(ASP_OFF_CTRL, 32'h40);
    rdc(ASP_OFF_STAT, 32'h0);
    rdc(5'h14, 32'h0);
    chk(32'(SERIAL_TRANSMIT_PIN), 32'h1);
    chk(32'(IRQ), 32'h0);
  endtask

  // Every timer source, each with its own bit time
  task automatic t_tx_src;
    int rl[6] = '{248, 254, 255, 255, 255, 255};
    int bc[6] = '{16, 16, 24, 96, 32, 4};
    logic [7:0] d;
    for (int s = 0; s < 6; s++) begin
      wr(ASP_OFF_TMR, {20'h0, 1'b1, 3'(s), 8'(rl[s])});
      i_remote.bit_cyc = bc[s];
      d = 8'h35 + 8'(s);
      wr(ASP_OFF_DATA, {24'h0, d});
      frame({2'b01, d, 1'b0});
      wr(ASP_OFF_STAT, 32'h3);
    end
  endtask

  // Nine-bit send, done flag timing, interrupt mask and clear
  task automatic t_tx9;
    int n;
    wr(ASP_OFF_TMR, 32'h8F8);
    i_remote.bit_cyc = 16;
    i_remote.nbits = 9;
    wr(ASP_OFF_CTRL, 32'h88);
    wr(ASP_OFF_MASK, 32'h2);
    n = 0;
    fork
      wr(ASP_OFF_DATA, 32'h5A);
      begin
        repeat (200) if (SERIAL_TRANSMIT_PIN !== 1'b0) @(posedge SYS_CLK);
        while (IRQ !== 1'b1 && n < 400) begin
          @(posedge SYS_CLK);
          n++;
        end
      end
    join
    chk(32'(n >= 159 && n <= 161), 32'h1);
    frame({2'b11, 8'h5A, 1'b0});
    repeat (50) @(posedge SYS_CLK);
    rdc(ASP_OFF_STAT, 32'h2);
    chk(32'(IRQ), 32'h1);
    wr(ASP_OFF_MASK, 32'h0);
    chk(32'(IRQ), 32'h0);
    wr(ASP_OFF_MASK, 32'h2);
    wr(ASP_OFF_STAT, 32'h2);
    chk(32'(IRQ), 32'h0);
    rdc(ASP_OFF_STAT, 32'h0);
  endtask

  // Receive, overrun drop, holding buffer and full duplex
  task automatic t_rx;
    i_remote.nbits = 8;
    wr(ASP_OFF_CTRL, 32'h10);
    i_remote.send(9'h0C3, 1'b1);
    wait_st(0);
    rdc(ASP_OFF_DATA, 32'hC3);
    rdc(ASP_OFF_CTRL, 32'h54);
    i_remote.send(9'h03C, 1'b1);
    repeat (20) @(posedge SYS_CLK);
    rdc(ASP_OFF_DATA, 32'hC3);
    fork
      i_remote.send(9'h096, 1'b1);
      begin
        repeat (40) @(posedge SYS_CLK);
        wr(ASP_OFF_DATA, 32'h11);
        wr(ASP_OFF_STAT, 32'h1);
        rdc(ASP_OFF_DATA, 32'hC3);
      end
    join
    wait_st(0);
    rdc(ASP_OFF_DATA, 32'h96);
    frame({2'b01, 8'h11, 1'b0});
    wr(ASP_OFF_STAT, 32'h3);
  endtask

  // Multiprocessor filter in both frame widths
  task automatic t_mce;
    wr(ASP_OFF_CTRL, 32'h30);
    i_remote.send(9'h077, 1'b0);
    repeat (20) @(posedge SYS_CLK);
    rdc(ASP_OFF_STAT, 32'h0);
    i_remote.nbits = 9;
    wr(ASP_OFF_CTRL, 32'hB0);
    i_remote.send(9'h0EE, 1'b1);
    repeat (20) @(posedge SYS_CLK);
    rdc(ASP_OFF_STAT, 32'h0);
    i_remote.send(9'h1DD, 1'b1);
    wait_st(0);
    rdc(ASP_OFF_DATA, 32'hDD);
    rdc(ASP_OFF_CTRL, 32'hF4);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    t_reset();
    t_tx_src();
    t_tx9();
    t_rx();
    t_mce();
    conclude();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    num_errors++;
    conclude();
  end
endmodule
